/* File: hw/lsef_map.svh */
// register offsets, field positions and reset values of the lin flag block
`ifndef LSEF_MAP_SVH
`define LSEF_MAP_SVH
// ==========================================
// register byte addresses
`define LSEF_STATUS_OFS 12'h000
`define LSEF_DATA_OFS 12'h004
`define LSEF_CTRL1_OFS 12'h008
`define LSEF_LINCTRL_OFS 12'h00c
`define LSEF_IRQ_MASK_OFS 12'h010
`define LSEF_IRQ_STAT_OFS 12'h014
// ==========================================
// status fields
`define LSEF_ST_NOISE 2
`define LSEF_ST_FRAME 1
`define LSEF_ST_PARITY 0
// ==========================================
// control one fields
`define LSEF_C1_RX9 7
`define LSEF_C1_TX9 6
`define LSEF_C1_DIS 5
`define LSEF_C1_WORD9 4
`define LSEF_C1_WAKE 3
`define LSEF_C1_PCE 2
`define LSEF_C1_RSVD 1
`define LSEF_C1_PIE 0
// ==========================================
// lin control fields
`define LSEF_LC_LINE 0
`define LSEF_LC_SLAVE 1
`define LSEF_LC_HDM 2
`define LSEF_LC_LPS 3
`define LSEF_LC_HDF 4
// ==========================================
// event bits and reset values
`define LSEF_EV_NOISE 0
`define LSEF_EV_FRAME 1
`define LSEF_EV_PARITY 2
`define LSEF_EV_HEADER 3
`define LSEF_CTRL1_RST 8'h00
`define LSEF_LINCTRL_RST 8'h00
`define LSEF_MASK_RST 4'h0
`endif

/* File: hw/lsef_pkg.sv */
// types of the lin flag block
package lsef_pkg;
    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_WRITE
    } lsef_bus_t;
    typedef struct packed {
        lsef_bus_t busSt;
        logic [11:0] addr;
        logic [7:0] ctrl1;
        logic [7:0] linCtrl;
        logic noise;
        logic frame;
        logic parity;
        logic header;
        logic armed;
        logic [2:0] armedMask;
        logic [3:0] irqStat;
        logic [3:0] irqMask;
        logic [31:0] rdata;
        logic irqSerial;
        logic irqLine;
        logic tx9;
        logic word9;
        logic stopPre;
        logic halted;
        logic wakeAddr;
        logic linRepl;
        logic pceOut;
    } lsef_state_t;
endpackage

/* File: hw/lsef_top.sv */
// lin serial error flags and first control register, ahb-lite slave
`timescale 1ns/1ns
`include "lsef_map.svh"
module lsef_top (
    input wire logic mclk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic rxDone,
    input wire logic rxNoise,
    input wire logic rxStopBit,
    input wire logic rxAnyRecessive,
    input wire logic rxBreak,
    input wire logic rxNinth,
    input wire logic rxParityErr,
    input wire logic byteEnd,
    output logic txNinthBit,
    output logic nineBitWords,
    output logic serialHalted,
    output logic wakeAddrMark,
    output logic linReplacement,
    output logic parityCheckOn,
    output logic serialIrq,
    output logic irq
);
    lsef_pkg::lsef_state_t st_r;
    lsef_pkg::lsef_state_t st_nxt;
    logic takeReq;
    logic [11:0] reqAddr;
    logic rdStatus;
    logic rdData;
    logic wrData;
    logic [3:0] evt;
    logic slaveLin;
    logic frameEv;
    logic parEv;
    logic [7:0] statusVal;
    logic [3:0] wmask;
    logic wordXfer;
    logic dataAcc;
    logic hdfClr;
    logic [2:0] flagNow;
    logic [2:0] flagEv;
    logic [2:0] flagClr;
    logic [2:0] flagNew;
    logic [3:0] irqNew;
    // ==========================================
    // request qualify
    // sub-word transfers are ignored, every register is one word
    always_comb begin
        wordXfer = (hsize == 3'h2);
        takeReq = hsel & hready & htrans[1] & wordXfer;
        reqAddr = haddr[11:0];
    end
    // ==========================================
    // outputs
    assign hrdata = st_r.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign txNinthBit = st_r.tx9;
    assign nineBitWords = st_r.word9;
    assign serialHalted = st_r.halted;
    assign wakeAddrMark = st_r.wakeAddr;
    assign linReplacement = st_r.linRepl;
    assign parityCheckOn = st_r.pceOut;
    assign serialIrq = st_r.irqSerial;
    assign irq = st_r.irqLine;
    // ==========================================
    // per-flag set and clear
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_flag
            // set wins over a clear in the same cycle
            logic keep;
            assign keep = flagNow[gi] & ~flagClr[gi];
            assign flagNew[gi] = keep | flagEv[gi];
        end
        for (gi = 0; gi < 4; gi++) begin : g_irq
            // read clears, an event in that cycle survives
            logic keep;
            assign keep = st_r.irqStat[gi] & ~wmask[gi];
            assign irqNew[gi] = keep | evt[gi];
        end
    endgenerate
    // ==========================================
    // bus strobes
    always_comb begin
        rdStatus = 1'b0;
        rdData = 1'b0;
        wrData = 1'b0;
        wmask = 4'h0;
        hdfClr = 1'b0;
        if (takeReq && !hwrite) begin
            case (reqAddr)
                `LSEF_STATUS_OFS: begin
                    rdStatus = 1'b1;
                end
                `LSEF_DATA_OFS: begin
                    rdData = 1'b1;
                end
                `LSEF_IRQ_STAT_OFS: begin
                    wmask = 4'hf;
                end
                default: begin
                end
            endcase
        end
        // ==========================================
        // write data phase strobes
        if (st_r.busSt == lsef_pkg::BUS_WRITE) begin
            case (st_r.addr)
                `LSEF_DATA_OFS: begin
                    wrData = 1'b1;
                end
                `LSEF_LINCTRL_OFS: begin
                    // header flag clear is a write of one
                    hdfClr = hwdata[`LSEF_LC_HDF];
                end
                default: begin
                end
            endcase
        end
        // a data write lands one cycle after its address phase
        dataAcc = rdData | wrData;
    end
    // ==========================================
    // event decode
    always_comb begin
        slaveLin = st_r.linCtrl[`LSEF_LC_LINE] & st_r.linCtrl[`LSEF_LC_SLAVE];
        frameEv = rxDone & ~rxStopBit & (~slaveLin | rxAnyRecessive);
        if (slaveLin & rxBreak) begin
            frameEv = 1'b0;
        end
        parEv = rxDone & rxParityErr & st_r.ctrl1[`LSEF_C1_PCE];
        evt = 4'h0;
        evt[`LSEF_EV_NOISE] = rxDone & rxNoise & ~slaveLin;
        evt[`LSEF_EV_FRAME] = frameEv;
        evt[`LSEF_EV_PARITY] = parEv;
        evt[`LSEF_EV_HEADER] = rxDone & rxBreak & slaveLin
            & ~st_r.linCtrl[`LSEF_LC_HDM];
        statusVal = {5'h00, st_r.noise, st_r.frame, st_r.parity};
        // ==========================================
        // flag set and clear terms
        flagNow = {st_r.noise, st_r.frame, st_r.parity};
        flagEv[2] = evt[`LSEF_EV_NOISE];
        flagEv[1] = evt[`LSEF_EV_FRAME];
        flagEv[0] = evt[`LSEF_EV_PARITY];
        // data read clears noise and framing
        flagClr[2] = st_r.armed & st_r.armedMask[2] & rdData;
        flagClr[1] = st_r.armed & st_r.armedMask[1] & rdData;
        flagClr[0] = st_r.armed & st_r.armedMask[0] & dataAcc;
    end
    // ==========================================
    // next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.rdata = 32'h0000_0000;
        st_nxt.busSt = lsef_pkg::BUS_IDLE;
        // ==========================================
        // data phase of a write
        if (st_r.busSt == lsef_pkg::BUS_WRITE) begin
            case (st_r.addr)
                `LSEF_CTRL1_OFS: begin
                    // reserved bit held clear
                    // rx ninth bit is kept, software cannot write it
                    st_nxt.ctrl1 = {st_r.ctrl1[7], hwdata[6:2], 1'b0,
                        hwdata[0]};
                end
                `LSEF_LINCTRL_OFS: begin
                    st_nxt.linCtrl = {4'h0, hwdata[3:0]};
                end
                `LSEF_IRQ_MASK_OFS: begin
                    st_nxt.irqMask = hwdata[3:0];
                end
                default: begin
                end
            endcase
        end
        // ==========================================
        // address phase, read data for the next cycle
        // read data stands only in the data phase
        if (takeReq) begin
            st_nxt.addr = reqAddr;
            if (hwrite) begin
                st_nxt.busSt = lsef_pkg::BUS_WRITE;
            end else begin
                case (reqAddr)
                    `LSEF_STATUS_OFS: begin
                        st_nxt.rdata = {24'h0, statusVal};
                    end
                    `LSEF_CTRL1_OFS: begin
                        st_nxt.rdata = {24'h0, st_r.ctrl1};
                    end
                    `LSEF_LINCTRL_OFS: begin
                        st_nxt.rdata = {27'h0, st_r.header,
                            st_r.linCtrl[3:0]};
                    end
                    `LSEF_IRQ_MASK_OFS: begin
                        st_nxt.rdata = {28'h0, st_r.irqMask};
                    end
                    `LSEF_IRQ_STAT_OFS: begin
                        st_nxt.rdata = {28'h0, st_r.irqStat};
                    end
                    default: begin
                        // data register has no storage, reads zero
                        st_nxt.rdata = 32'h0000_0000;
                    end
                endcase
            end
        end
        // ==========================================
        // flags, arm on status read
        // remember flags that were set at the status read
        // a status read in the same cycle re-arms with fresh flags
        if (rdStatus) begin
            st_nxt.armed = 1'b1;
            st_nxt.armedMask = flagNow;
        end else if (st_r.armed & dataAcc) begin
            st_nxt.armed = 1'b0;
        end
        st_nxt.noise = flagNew[2];
        st_nxt.frame = flagNew[1];
        st_nxt.parity = flagNew[0];
        // header flag, write one clears, set wins
        if (evt[`LSEF_EV_HEADER]) begin
            st_nxt.header = 1'b1;
        end else if (hdfClr) begin
            st_nxt.header = 1'b0;
        end
        st_nxt.irqStat = irqNew;
        // ==========================================
        // ninth bit and frame format
        // capture ninth bit in nine-bit mode
        if (rxDone & st_r.ctrl1[`LSEF_C1_WORD9]) begin
            st_nxt.ctrl1[`LSEF_C1_RX9] = rxNinth;
        end
        // word bit selects eight or nine data
        // word bit is not guarded against change mid-frame
        st_nxt.word9 = st_nxt.ctrl1[`LSEF_C1_WORD9];
        // ninth bit out only in nine-bit mode
        if (st_nxt.word9) begin
            st_nxt.tx9 = st_nxt.ctrl1[`LSEF_C1_TX9];
        end else begin
            st_nxt.tx9 = 1'b0;
        end
        // ==========================================
        // low power disable
        // stop waits for the byte to end
        // clearing disable releases the outputs at once
        st_nxt.stopPre = st_nxt.ctrl1[`LSEF_C1_DIS];
        if (!st_nxt.stopPre) begin
            st_nxt.halted = 1'b0;
        end else if (byteEnd | st_r.halted) begin
            st_nxt.halted = 1'b1;
        end
        // ==========================================
        // wake method and parity control
        // wake bit reused in lin mode
        // the line enable decides which meaning the bit takes
        if (st_nxt.linCtrl[`LSEF_LC_LINE]) begin
            st_nxt.wakeAddr = 1'b0;
            st_nxt.linRepl = st_nxt.ctrl1[`LSEF_C1_WAKE];
        end else begin
            st_nxt.wakeAddr = st_nxt.ctrl1[`LSEF_C1_WAKE];
            st_nxt.linRepl = 1'b0;
        end
        st_nxt.pceOut = st_nxt.ctrl1[`LSEF_C1_PCE];
        // ==========================================
        // interrupts
        // parity interrupt, byte or lin parity
        // lin parity select only names the error kind
        // both interrupt outputs are levels, no pulse stretching
        st_nxt.irqSerial = st_nxt.parity & st_nxt.ctrl1[`LSEF_C1_PIE]
            & st_nxt.ctrl1[`LSEF_C1_PCE];
        st_nxt.irqLine = |(st_nxt.irqStat & st_nxt.irqMask);
    end
    // ==========================================
    // state register
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            // reset branch holds constants only
            st_r.busSt <= lsef_pkg::BUS_IDLE;
            st_r.addr <= 12'h000;
            st_r.ctrl1 <= `LSEF_CTRL1_RST;
            st_r.linCtrl <= `LSEF_LINCTRL_RST;
            st_r.noise <= 1'b0;
            st_r.frame <= 1'b0;
            st_r.parity <= 1'b0;
            st_r.header <= 1'b0;
            st_r.armed <= 1'b0;
            st_r.armedMask <= 3'h0;
            st_r.irqStat <= 4'h0;
            st_r.irqMask <= `LSEF_MASK_RST;
            st_r.rdata <= 32'h0000_0000;
            st_r.irqSerial <= 1'b0;
            st_r.irqLine <= 1'b0;
            st_r.tx9 <= 1'b0;
            st_r.word9 <= 1'b0;
            st_r.stopPre <= 1'b0;
            st_r.halted <= 1'b0;
            st_r.wakeAddr <= 1'b0;
            st_r.linRepl <= 1'b0;
            st_r.pceOut <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule // lsef_top

/* File: tb/lsef_chk.sv */
// port checker for the lin serial flag block
`timescale 1ns/1ns
module lsef_chk (
    input wire logic mclk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic rxDone,
    input wire logic byteEnd,
    input wire logic txNinthBit,
    input wire logic nineBitWords,
    input wire logic serialHalted,
    input wire logic wakeAddrMark,
    input wire logic linReplacement,
    input wire logic parityCheckOn,
    input wire logic serialIrq,
    input wire logic irq
);
    // ====
    // cycles since last cause, saturating
    logic [2:0] sinceEnd_r;
    logic [2:0] sinceRx_r;
    logic [2:0] sinceAcc_r;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sinceEnd_r <= 3'h7;
            sinceRx_r <= 3'h7;
            sinceAcc_r <= 3'h7;
        end else begin
            sinceEnd_r <= byteEnd ? 3'h0 : sinceEnd_r + {2'h0, ~&sinceEnd_r};
            sinceRx_r <= rxDone ? 3'h0 : sinceRx_r + {2'h0, ~&sinceRx_r};
            sinceAcc_r <= (hsel && hready && htrans[1]) ? 3'h0
                : sinceAcc_r + {2'h0, ~&sinceAcc_r};
        end
    end
    default clocking dc @(posedge mclk);
    endclocking
    default disable iff (rst);
    sequence rxToIrq;
        rxDone ##1 $rose(serialIrq);
    endsequence
    COV_RX_IRQ: cover property (rxToIrq);
    AST_BUS_OKAY: assert property (hreadyout && !hresp)
        else $error("slave stalled or not okay");
    AST_SIRQ_PCE: assert property (serialIrq |-> parityCheckOn)
        else $error("serial irq with parity check off");
    AST_WAKE_LIN: assert property (!(wakeAddrMark && linReplacement))
        else $error("wake bit drives both meanings");
    AST_TX9_WORD: assert property (txNinthBit |-> nineBitWords)
        else $error("ninth tx bit outside nine-bit mode");
    AST_HALT_END: assert property ($rose(serialHalted) |-> sinceEnd_r <= 3'h3)
        else $error("halt without byte end");
    AST_IRQ_FALL: assert property ($fell(irq) |-> sinceAcc_r <= 3'h4)
        else $error("irq dropped without bus access");
    AST_SIRQ_FALL: assert property ($fell(serialIrq) |-> sinceAcc_r <= 3'h4)
        else $error("serial irq dropped without access");
    AST_SIRQ_RISE: assert property ($rose(serialIrq)
        |-> sinceRx_r <= 3'h3 || sinceAcc_r <= 3'h4)
        else $error("serial irq rose without cause");
endmodule // lsef_chk
bind lsef_top lsef_chk u_lsef_chk (.mclk, .rst, .hsel, .htrans, .hready,
    .hreadyout, .hresp, .rxDone, .byteEnd, .txNinthBit, .nineBitWords,
    .serialHalted, .wakeAddrMark, .linReplacement, .parityCheckOn,
    .serialIrq, .irq);

/* File: tb/lsef_node_model.sv */
// far-side node model raising receive and byte-end events
`timescale 1ns/1ns
module lsef_node_model (
    input wire logic mclk,
    input wire logic rst,
    input wire logic go,
    input wire logic [5:0] pat,
    input wire logic endReq,
    output logic rxDone,
    output logic [5:0] fields,
    output logic byteEnd
);
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rxDone <= 1'b0;
            fields <= 6'h00;
            byteEnd <= 1'b0;
        end else begin
            rxDone <= go;
            // unqualified fields toggle so stale values never pass
            fields <= go ? pat : ~fields;
            byteEnd <= endReq;
        end
    end
endmodule // lsef_node_model

/* File: tb/test_lsef_top.sv */
// self-checking bench for the lin serial flag block
`timescale 1ns/1ns
`include "lsef_map.svh"
module test_lsef_top;
    logic mclk, rst, hsel, hwrite, go, endReq, rxDone, byteEnd, hreadyout;
    logic hresp, txNinthBit, nineBitWords, serialHalted, wakeAddrMark;
    logic linReplacement, parityCheckOn, serialIrq, irq;
    logic [31:0] haddr, hwdata, hrdata, q, hrdataS;
    logic [1:0] htrans;
    logic [5:0] pat, fields;
    int failures = 0, checked = 0, cycles = 0;
    lsef_top u_lsef_top (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .rxDone(rxDone), .rxNoise(fields[5]),
        .rxStopBit(fields[4]), .rxAnyRecessive(fields[3]),
        .rxBreak(fields[2]), .rxNinth(fields[1]), .rxParityErr(fields[0]),
        .byteEnd(byteEnd), .txNinthBit(txNinthBit),
        .nineBitWords(nineBitWords), .serialHalted(serialHalted),
        .wakeAddrMark(wakeAddrMark), .linReplacement(linReplacement),
        .parityCheckOn(parityCheckOn), .serialIrq(serialIrq), .irq(irq));
    lsef_node_model u_lsef_node_model (.mclk(mclk), .rst(rst), .go(go),
        .pat(pat), .endReq(endReq), .rxDone(rxDone), .fields(fields),
        .byteEnd(byteEnd));
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    // read data held from mid data phase, taken at the closing edge
    always @(negedge mclk) hrdataS = hrdata;
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            failures++;
            final_report;
        end
    end
    // ====
    // compares and bus cycles
    task automatic chkv(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t reg %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chkb(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t port %b exp %b", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge mclk);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        @(posedge mclk);
        while (hreadyout !== 1'b1) @(posedge mclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge mclk);
        while (hreadyout !== 1'b1) @(posedge mclk);
        q = hrdataS;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chkv(q, exp);
    endtask
    task automatic ev(input logic [5:0] p);
        @(posedge mclk);
        go <= 1'b1;
        pat <= p;
        @(posedge mclk);
        go <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask
    task automatic final_report;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // ====
    // scenarios
    task automatic t_regs;
        rd(`LSEF_CTRL1_OFS, 32'h0);
        rd(12'h0f0, 32'h0);
        bus(1'b1, `LSEF_CTRL1_OFS, 32'hff);
        rd(`LSEF_CTRL1_OFS, 32'h7d);
        chkb(nineBitWords, 1'b1);
        chkb(txNinthBit, 1'b1);
        chkb(parityCheckOn, 1'b1);
        chkb(wakeAddrMark, 1'b1);
        bus(1'b1, `LSEF_CTRL1_OFS, 32'h48);
        bus(1'b1, `LSEF_LINCTRL_OFS, 32'h1);
        repeat (2) @(posedge mclk);
        chkb(txNinthBit, 1'b0);
        chkb(wakeAddrMark, 1'b0);
        chkb(linReplacement, 1'b1);
    endtask
    task automatic t_halt;
        bus(1'b1, `LSEF_CTRL1_OFS, 32'h30);
        repeat (3) @(posedge mclk);
        chkb(serialHalted, 1'b0);
        endReq <= 1'b1;
        @(posedge mclk);
        endReq <= 1'b0;
        // word bit fixed before the frame
        ev(6'h12);
        chkb(serialHalted, 1'b1);
        rd(`LSEF_CTRL1_OFS, 32'hb0);
        bus(1'b1, `LSEF_CTRL1_OFS, 32'h05);
        repeat (2) @(posedge mclk);
        chkb(serialHalted, 1'b0);
    endtask
    task automatic t_parity;
        bus(1'b1, `LSEF_IRQ_MASK_OFS, 32'h4);
        bus(1'b0, `LSEF_IRQ_STAT_OFS, 32'h0);
        ev(6'h11);
        chkb(serialIrq, 1'b1);
        chkb(irq, 1'b1);
        rd(`LSEF_IRQ_STAT_OFS, 32'h4);
        rd(`LSEF_DATA_OFS, 32'h0);
        rd(`LSEF_STATUS_OFS, 32'h1);
        bus(1'b1, `LSEF_DATA_OFS, 32'h0);
        rd(`LSEF_STATUS_OFS, 32'h0);
        chkb(serialIrq, 1'b0);
        chkb(irq, 1'b0);
        bus(1'b1, `LSEF_LINCTRL_OFS, 32'h9);
        ev(6'h11);
        chkb(serialIrq, 1'b1);
        bus(1'b1, `LSEF_CTRL1_OFS, 32'h01);
        rd(`LSEF_STATUS_OFS, 32'h1);
        bus(1'b1, `LSEF_DATA_OFS, 32'h0);
        ev(6'h11);
        rd(`LSEF_STATUS_OFS, 32'h0);
    endtask
    task automatic t_frame;
        bus(1'b1, `LSEF_LINCTRL_OFS, 32'h3);
        ev(6'h08);
        rd(`LSEF_STATUS_OFS, 32'h2);
        rd(`LSEF_DATA_OFS, 32'h0);
        rd(`LSEF_STATUS_OFS, 32'h0);
        ev(6'h00);
        ev(6'h04);
        ev(6'h30);
        rd(`LSEF_STATUS_OFS, 32'h0);
        rd(`LSEF_LINCTRL_OFS, 32'h13);
        bus(1'b1, `LSEF_LINCTRL_OFS, 32'h11);
        ev(6'h30);
        rd(`LSEF_STATUS_OFS, 32'h4);
    endtask
    initial begin
        rst = 1'b1;
        hsel = 1'b0;
        hwrite = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwdata = 32'h0;
        go = 1'b0;
        pat = 6'h00;
        endReq = 1'b0;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        t_regs;
        t_halt;
        t_parity;
        t_frame;
        final_report;
    end
endmodule // test_lsef_top
